// [rtl/pm_cfg_pkg.sv]
// Constants for the power management control/status and index/data I/O base logic.
// Assumes configuration offsets are byte addresses of aligned 32-bit words.
package pm_cfg_pkg;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] OFF_POWER_MGMT_CTRL_STATUS = 8'h54;
	localparam logic [7:0] OFF_INDEX_DATA_IO_BASE = 8'h58;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int WAKE_STATUS_BIT = 15;
	localparam int WAKE_ENABLE_BIT = 8;
	localparam int PSTATE_LSB = 0;
	localparam int PSTATE_MSB = 1;
	localparam int BASE_LSB = 1;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [15:0] PMCSR_RESET = 16'h0000;
	localparam logic [31:0] BASE_RESET = 32'h0000_0000;

	// ****************************************
	// Power state encodings
	// ****************************************
	localparam logic [1:0] PSTATE_D0 = 2'h0;
	localparam logic [1:0] PSTATE_D1 = 2'h1;
	localparam logic [1:0] PSTATE_D2 = 2'h2;
	localparam logic [1:0] PSTATE_D3HOT = 2'h3;

	// ****************************************
	// Index/data offsets from the I/O base
	// ****************************************
	localparam logic [31:0] INDEX_OFFSET = 32'h0000_0000;
	localparam logic [31:0] DATA_OFFSET = 32'h0000_0001;
endpackage

// [rtl/index_data_port.sv]
// Index/data register pair decoded from host I/O cycles at a programmable base.
// Assumes I/O strobes are single-cycle and synchronous to mclk.
`timescale 1ns/1ns
`default_nettype none
module index_data_port
	import pm_cfg_pkg::*;
#(
	parameter int DATA_W = 32,
	parameter int IDX_W = 8
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic pci_rst_n,
	input wire logic [31:0] io_base,
	input wire logic io_rd,
	input wire logic io_wr,
	input wire logic [31:0] io_addr,
	input wire logic [DATA_W-1:0] io_wdata,
	input wire logic [DATA_W-1:0] hpc_rdata,
	output logic io_claim,
	output logic [DATA_W-1:0] io_rdata,
	output logic [IDX_W-1:0] hpc_index,
	output logic hpc_wr,
	output logic hpc_rd,
	output logic [DATA_W-1:0] hpc_wdata
);
	typedef struct packed {
		logic claim;
		logic [DATA_W-1:0] rdata;
		logic [IDX_W-1:0] index;
		logic wr;
		logic rd;
		logic [DATA_W-1:0] wdata;
	} port_state_s;

	port_state_s s_q, s_d;
	logic base_valid, hit_idx, hit_dat;

	// ****************************************
	// Address decode
	// ****************************************
	always_comb begin
		base_valid = (io_base != BASE_RESET);
		hit_idx = base_valid && (io_addr == io_base + INDEX_OFFSET);
		hit_dat = base_valid && (io_addr == io_base + DATA_OFFSET);
	end

	always_comb begin
		s_d = s_q;
		s_d.claim = (io_rd || io_wr) && (hit_idx || hit_dat);
		s_d.wr = io_wr && hit_dat;
		s_d.rd = io_rd && hit_dat;
		s_d.rdata = '0;
		if (io_wr && hit_dat) begin
			s_d.wdata = io_wdata;
		end
		if (io_wr && hit_idx) begin
			s_d.index = io_wdata[IDX_W-1:0];
		end
		if (io_rd && hit_idx) begin
			s_d.rdata = DATA_W'(s_q.index);
		end else if (io_rd && hit_dat) begin
			s_d.rdata = hpc_rdata;
		end
		if (!pci_rst_n) begin
			s_d = '0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign io_claim = s_q.claim;
	assign io_rdata = s_q.rdata;
	assign hpc_index = s_q.index;
	assign hpc_wr = s_q.wr;
	assign hpc_rd = s_q.rd;
	assign hpc_wdata = s_q.wdata;

	// ****************************************
	// Checks
	// ****************************************
	property p_claim_match;
		@(posedge mclk) disable iff (!rst_n)
		(pci_rst_n && io_rd && io_base != 32'h0 && io_addr == io_base) |=> io_claim;
	endproperty
	a_claim_match: assert property (p_claim_match) else $error("Index address not claimed");

	property p_no_claim_zero;
		@(posedge mclk) disable iff (!rst_n)
		(io_base == 32'h0) |=> !io_claim;
	endproperty
	a_no_claim_zero: assert property (p_no_claim_zero) else $error("Claim with zero base");

	property p_data_strobe;
		@(posedge mclk) disable iff (!rst_n)
		(pci_rst_n && io_wr && io_base != 32'h0 && io_addr == io_base + 32'h1)
		|=> (hpc_wr && hpc_wdata == $past(io_wdata));
	endproperty
	a_data_strobe: assert property (p_data_strobe) else $error("Data write not forwarded");
endmodule
`default_nettype wire

// [rtl/pm_csr_block.sv]
// Power management control/status register and index/data I/O base register.
// Assumes one-cycle configuration strobes with a byte-address offset, synchronous to mclk.
`timescale 1ns/1ns
`default_nettype none
module pm_csr_block
	import pm_cfg_pkg::*;
#(
	parameter int DATA_W = 32,
	parameter int IDX_W = 8
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic pci_rst_n,
	input wire logic cfg_rd,
	input wire logic cfg_wr,
	input wire logic [7:0] cfg_addr,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	output logic cfg_ack,
	output logic [31:0] cfg_rdata,
	input wire logic wake_event,
	output logic wake_oe,
	output logic [1:0] power_state,
	output logic std_cfg_reset,
	input wire logic io_rd,
	input wire logic io_wr,
	input wire logic [31:0] io_addr,
	input wire logic [DATA_W-1:0] io_wdata,
	output logic io_claim,
	output logic [DATA_W-1:0] io_rdata,
	input wire logic [DATA_W-1:0] hpc_rdata,
	output logic [IDX_W-1:0] hpc_index,
	output logic hpc_wr,
	output logic hpc_rd,
	output logic [DATA_W-1:0] hpc_wdata
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic wake_status;
		logic wake_enable;
		logic [1:0] pstate;
		logic [31:BASE_LSB] base;
		logic wake_pin;
		logic cfg_rst;
		logic ack;
		logic [31:0] rdata;
	} csr_state_s;

	csr_state_s s_q, s_d;
	logic wr_pm, wr_base, rd_pm, rd_base;
	logic [15:0] pm_view;
	logic [31:0] base_view;

	function automatic logic hits(input logic [7:0] a, input logic [7:0] off);
		return a[7:2] == off[7:2];
	endfunction

	// ****************************************
	// Decode and read views
	// ****************************************
	always_comb begin
		wr_pm = pci_rst_n && cfg_wr && hits(cfg_addr, OFF_POWER_MGMT_CTRL_STATUS);
		wr_base = pci_rst_n && cfg_wr && hits(cfg_addr, OFF_INDEX_DATA_IO_BASE);
		rd_pm = pci_rst_n && cfg_rd && hits(cfg_addr, OFF_POWER_MGMT_CTRL_STATUS);
		rd_base = pci_rst_n && cfg_rd && hits(cfg_addr, OFF_INDEX_DATA_IO_BASE);
		pm_view = PMCSR_RESET;
		pm_view[WAKE_STATUS_BIT] = s_q.wake_status;
		pm_view[WAKE_ENABLE_BIT] = s_q.wake_enable;
		pm_view[PSTATE_MSB:PSTATE_LSB] = s_q.pstate;
		base_view = {s_q.base, 1'b0};
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_d = s_q;
		s_d.ack = cfg_rd || cfg_wr;
		s_d.rdata = '0;
		s_d.cfg_rst = 1'b0;
		if (rd_pm) begin
			s_d.rdata = {16'h0000, pm_view};
		end else if (rd_base) begin
			s_d.rdata = base_view;
		end
		if (wr_pm && cfg_be[1]) begin
			if (cfg_wdata[WAKE_STATUS_BIT]) begin
				s_d.wake_status = 1'b0;
			end
			s_d.wake_enable = cfg_wdata[WAKE_ENABLE_BIT];
		end
		if (wr_pm && cfg_be[0]) begin
			s_d.pstate = cfg_wdata[PSTATE_MSB:PSTATE_LSB];
			if (s_q.pstate == PSTATE_D3HOT && s_d.pstate == PSTATE_D0) begin
				s_d.cfg_rst = 1'b1;
			end
		end
		if (wr_base) begin
			if (cfg_be[0]) s_d.base[7:1] = cfg_wdata[7:1];
			if (cfg_be[1]) s_d.base[15:8] = cfg_wdata[15:8];
			if (cfg_be[2]) s_d.base[23:16] = cfg_wdata[23:16];
			if (cfg_be[3]) s_d.base[31:24] = cfg_wdata[31:24];
		end
		if (wake_event) begin
			s_d.wake_status = 1'b1;
		end
		if (!pci_rst_n) begin
			s_d.pstate = PSTATE_D0;
			s_d.base = '0;
			s_d.cfg_rst = 1'b0;
			s_d.ack = 1'b0;
		end
		s_d.wake_pin = s_d.wake_status && s_d.wake_enable;
	end

	// Internal reset pulse reaches only the standard registers outside; nothing here uses it
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign cfg_ack = s_q.ack;
	assign cfg_rdata = s_q.rdata;
	assign wake_oe = s_q.wake_pin;
	assign power_state = s_q.pstate;
	assign std_cfg_reset = s_q.cfg_rst;

	// ****************************************
	// Index/data port
	// ****************************************
	index_data_port #(
		.DATA_W(DATA_W),
		.IDX_W(IDX_W)
	) u_port (
		.mclk(mclk),
		.rst_n(rst_n),
		.pci_rst_n(pci_rst_n),
		.io_base({s_q.base, 1'b0}),
		.io_rd(io_rd),
		.io_wr(io_wr),
		.io_addr(io_addr),
		.io_wdata(io_wdata),
		.hpc_rdata(hpc_rdata),
		.io_claim(io_claim),
		.io_rdata(io_rdata),
		.hpc_index(hpc_index),
		.hpc_wr(hpc_wr),
		.hpc_rd(hpc_rd),
		.hpc_wdata(hpc_wdata)
	);

	// ****************************************
	// Checks
	// ****************************************
	property p_status_set;
		@(posedge mclk) disable iff (!rst_n)
		wake_event |=> s_q.wake_status;
	endproperty
	a_status_set: assert property (p_status_set) else $error("Wake status not set");

	property p_status_clear;
		@(posedge mclk) disable iff (!rst_n)
		(wr_pm && cfg_be[1] && cfg_wdata[15] && !wake_event) |=> (!s_q.wake_status && !wake_oe);
	endproperty
	a_status_clear: assert property (p_status_clear) else $error("Wake status not cleared");

	property p_status_hold;
		@(posedge mclk) disable iff (!rst_n)
		(!pci_rst_n && s_q.wake_status) |=> s_q.wake_status;
	endproperty
	a_status_hold: assert property (p_status_hold) else $error("Bus reset cleared wake status");

	property p_pin_gated;
		@(posedge mclk) disable iff (!rst_n)
		wake_oe |-> (s_q.wake_enable && s_q.wake_status);
	endproperty
	a_pin_gated: assert property (p_pin_gated) else $error("Wake driven while disabled");

	property p_enable_hold;
		@(posedge mclk) disable iff (!rst_n)
		(!pci_rst_n && !cfg_wr) |=> $stable(s_q.wake_enable);
	endproperty
	a_enable_hold: assert property (p_enable_hold) else $error("Bus reset changed wake enable");

	property p_state_write;
		@(posedge mclk) disable iff (!rst_n)
		(pci_rst_n && wr_pm && cfg_be[0]) |=> (power_state == $past(cfg_wdata[1:0]));
	endproperty
	a_state_write: assert property (p_state_write) else $error("Power state not updated");

	property p_zero_fields;
		@(posedge mclk) disable iff (!rst_n)
		(rd_pm && pci_rst_n) |=> (cfg_ack && cfg_rdata[14:9] == 6'h00 && cfg_rdata[7:2] == 6'h00);
	endproperty
	a_zero_fields: assert property (p_zero_fields) else $error("Zero fields not zero");

	property p_d3_exit;
		@(posedge mclk) disable iff (!rst_n)
		(pci_rst_n && wr_pm && cfg_be[0] && power_state == 2'h3 && cfg_wdata[1:0] == 2'h0)
		|=> std_cfg_reset ##1 !std_cfg_reset;
	endproperty
	a_d3_exit: assert property (p_d3_exit) else $error("No internal reset on D3hot exit");

	property p_reset_keeps;
		@(posedge mclk) disable iff (!rst_n)
		std_cfg_reset |-> ($stable(s_q.base) && $stable(s_q.wake_enable));
	endproperty
	a_reset_keeps: assert property (p_reset_keeps) else $error("Internal reset changed registers");

	property p_base_bit0;
		@(posedge mclk) disable iff (!rst_n)
		(rd_base && pci_rst_n) |=> (cfg_rdata[0] == 1'b0);
	endproperty
	a_base_bit0: assert property (p_base_bit0) else $error("Base bit 0 not zero");

	property p_csr_kept;
		@(posedge mclk) disable iff (!rst_n)
		(pci_rst_n && std_cfg_reset && !wake_event && !wr_pm)
		|=> ($stable(s_q.wake_status) && $stable(s_q.wake_enable) && $stable(power_state));
	endproperty
	a_csr_kept: assert property (p_csr_kept) else $error("Internal reset changed the CSR");

	property p_base_write;
		@(posedge mclk) disable iff (!rst_n)
		(wr_base && cfg_be == 4'hF) |=> ({s_q.base, 1'b0} == ($past(cfg_wdata) & 32'hFFFF_FFFE));
	endproperty
	a_base_write: assert property (p_base_write) else $error("Base write lost");

	property p_enable_write;
		@(posedge mclk) disable iff (!rst_n)
		(wr_pm && cfg_be[1]) |=> (s_q.wake_enable == $past(cfg_wdata[8]));
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("Wake enable not written");

	property p_pin_follows;
		@(posedge mclk) disable iff (!rst_n)
		(wake_event && s_q.wake_enable && !wr_pm) |=> wake_oe;
	endproperty
	a_pin_follows: assert property (p_pin_follows) else $error("Wake not driven while enabled");

	property p_status_write0;
		@(posedge mclk) disable iff (!rst_n)
		(wr_pm && cfg_be[1] && !cfg_wdata[15] && s_q.wake_status) |=> s_q.wake_status;
	endproperty
	a_status_write0: assert property (p_status_write0) else $error("Writing 0 cleared status");

	property p_status_idle;
		@(posedge mclk) disable iff (!rst_n)
		(!wake_event && !s_q.wake_status) |=> !s_q.wake_status;
	endproperty
	a_status_idle: assert property (p_status_idle) else $error("Wake status set without event");

	property p_bus_reset;
		@(posedge mclk) disable iff (!rst_n)
		!pci_rst_n |=> (!cfg_ack && power_state == PSTATE_D0 && {s_q.base, 1'b0} == BASE_RESET);
	endproperty
	a_bus_reset: assert property (p_bus_reset) else $error("Bus reset not applied");

	property p_reset_cause;
		@(posedge mclk) disable iff (!rst_n)
		std_cfg_reset |-> ($past(power_state) == PSTATE_D3HOT && power_state == PSTATE_D0);
	endproperty
	a_reset_cause: assert property (p_reset_cause) else $error("Internal reset without D3hot exit");

	property p_status_read;
		@(posedge mclk) disable iff (!rst_n)
		rd_pm |=> (cfg_rdata[WAKE_STATUS_BIT] == $past(s_q.wake_status));
	endproperty
	a_status_read: assert property (p_status_read) else $error("Wake status read wrong");

	property p_state_read;
		@(posedge mclk) disable iff (!rst_n)
		rd_pm |=> (cfg_rdata[1:0] == $past(power_state));
	endproperty
	a_state_read: assert property (p_state_read) else $error("Power state read wrong");

	property p_state_hold;
		@(posedge mclk) disable iff (!rst_n)
		(pci_rst_n && !wr_pm) |=> $stable(power_state);
	endproperty
	a_state_hold: assert property (p_state_hold) else $error("Power state moved without write");

	property p_base_hold;
		@(posedge mclk) disable iff (!rst_n)
		(pci_rst_n && !wr_base) |=> $stable(s_q.base);
	endproperty
	a_base_hold: assert property (p_base_hold) else $error("Base moved without write");
endmodule
`default_nettype wire

// [test/host_bridge_model.sv]
// Host bridge model issuing configuration and I/O cycles.
// Assumes one-cycle strobes answered by a one-cycle registered pulse.
`timescale 1ns/1ns
`default_nettype none
module host_bridge_model (
	input wire logic mclk,
	input wire logic cfg_ack,
	input wire logic [31:0] cfg_rdata,
	input wire logic io_claim,
	input wire logic [31:0] io_rdata,
	output logic cfg_rd,
	output logic cfg_wr,
	output logic [7:0] cfg_addr,
	output logic [3:0] cfg_be,
	output logic [31:0] cfg_wdata,
	output logic io_rd,
	output logic io_wr,
	output logic [31:0] io_addr,
	output logic [31:0] io_wdata
);
	// ****************************************
	// Idle bus
	// ****************************************
	initial begin
		{cfg_rd, cfg_wr, io_rd, io_wr} = 4'h0;
		{cfg_addr, cfg_be, cfg_wdata, io_addr, io_wdata} = '0;
	end
	// ****************************************
	// Cycles
	// ****************************************
	task automatic cfg(input logic w, input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d, output logic [31:0] q, output logic ok);
		int n;
		@(posedge mclk);
		cfg_wr <= w;
		cfg_rd <= !w;
		cfg_addr <= a;
		cfg_be <= be;
		cfg_wdata <= d;
		@(posedge mclk);
		{cfg_wr, cfg_rd} <= 2'h0;
		cfg_wdata <= ~d;
		#1;
		n = 0;
		while (cfg_ack !== 1'b1 && n < 3) begin
			@(posedge mclk);
			#1;
			n++;
		end
		ok = (cfg_ack === 1'b1);
		q = cfg_rdata;
	endtask
	task automatic io(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic ok);
		@(posedge mclk);
		io_wr <= w;
		io_rd <= !w;
		io_addr <= a;
		io_wdata <= d;
		@(posedge mclk);
		{io_wr, io_rd} <= 2'h0;
		io_wdata <= ~d;
		#1;
		ok = (io_claim === 1'b1);
		q = io_rdata;
	endtask
endmodule
`default_nettype wire

// [test/pci_power_state_and_io_index_base_tb.sv]
// Self-checking bench for the power management and index/data base block.
// Assumes the host bridge model drives all configuration and I/O cycles.
`timescale 1ns/1ns
`default_nettype none
module pci_power_state_and_io_index_base_tb;
	import pm_cfg_pkg::*;
	logic mclk, rst_n, pci_rst_n, wake_event, cfg_rd, cfg_wr, cfg_ack, io_rd, io_wr, io_claim;
	logic wake_oe, std_cfg_reset, hpc_wr, hpc_rd, ok;
	logic [1:0] power_state;
	logic [3:0] cfg_be;
	logic [7:0] cfg_addr, hpc_index;
	logic [31:0] cfg_wdata, cfg_rdata, io_addr, io_wdata, io_rdata, hpc_rdata, hpc_wdata, q, b, d;
	int bad_count, compares, sr_cnt, i;
	// ****************************************
	// Clock, parts
	// ****************************************
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) if (std_cfg_reset === 1'b1) sr_cnt++;
	host_bridge_model host (.mclk(mclk), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
		.io_claim(io_claim), .io_rdata(io_rdata), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
		.cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .io_rd(io_rd),
		.io_wr(io_wr), .io_addr(io_addr), .io_wdata(io_wdata));
	pm_csr_block uut (.mclk(mclk), .rst_n(rst_n), .pci_rst_n(pci_rst_n), .cfg_rd(cfg_rd),
		.cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
		.cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .wake_event(wake_event), .wake_oe(wake_oe),
		.power_state(power_state), .std_cfg_reset(std_cfg_reset), .io_rd(io_rd), .io_wr(io_wr),
		.io_addr(io_addr), .io_wdata(io_wdata), .io_claim(io_claim), .io_rdata(io_rdata),
		.hpc_rdata(hpc_rdata), .hpc_index(hpc_index), .hpc_wr(hpc_wr), .hpc_rd(hpc_rd),
		.hpc_wdata(hpc_wdata));
	// ****************************************
	// Tasks
	// ****************************************
	function automatic logic [31:0] pm(input logic s, input logic e, input logic [1:0] p);
		return {16'h0000, s, 6'h00, e, 6'h00, p};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t %s got %h expected %h", $time, m, got, exp);
		end
	endtask
	task automatic rg(input logic w, input logic [7:0] a, input logic [31:0] v);
		host.cfg(w, a, (a == OFF_POWER_MGMT_CTRL_STATUS) ? 4'h3 : 4'hF, v, q, ok);
		chk({31'h0, ok}, 32'h1, "config ack");
	endtask
	task automatic pulse(input logic l);
		@(posedge mclk);
		if (l) wake_event <= 1'b1;
		else pci_rst_n <= 1'b0;
		@(posedge mclk);
		{wake_event, pci_rst_n} <= 2'h1;
		@(posedge mclk);
		#1;
	endtask
	task automatic results;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge mclk);
		bad_count++;
		$display("BAD %0t watchdog expired", $time);
		results;
	end
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		{rst_n, wake_event, sr_cnt, bad_count, compares} = '0;
		pci_rst_n = 1'b1;
		hpc_rdata = $urandom(87789);
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		rg(0, OFF_POWER_MGMT_CTRL_STATUS, 0);
		chk(q, 32'h0, "pm reset");
		rg(0, OFF_INDEX_DATA_IO_BASE, 0);
		chk(q, 32'h0, "base reset");
		rg(0, 8'h5C, 0);
		chk(q, 32'h0, "unmapped");
		$display("test reset done");
		host.io(1, 32'h0, 32'h5, q, ok);
		chk({31'h0, ok}, 32'h0, "claim before base");
		b = ($urandom() & 32'hFFFF_FFF0) | 32'h10;
		rg(1, OFF_INDEX_DATA_IO_BASE, b | 32'h1);
		rg(0, OFF_INDEX_DATA_IO_BASE, 0);
		chk(q, b, "base readback");
		for (i = 0; i < 4; i++) begin
			d = $urandom();
			host.io(1, b, d, q, ok);
			chk({hpc_index, 23'h0, ok}, {d[7:0], 24'h1}, "index write");
			host.io(0, b, 0, q, ok);
			chk(q, {24'h0, d[7:0]}, "index read");
			d = $urandom();
			host.io(1, b + 32'h1, d, q, ok);
			chk(hpc_wdata, d, "data write");
			chk({31'h0, ok}, 32'h1, "data claim");
			chk({31'h0, hpc_wr}, 32'h1, "data strobe");
			@(posedge mclk);
			hpc_rdata <= $urandom();
			host.io(0, b + 32'h1, 0, q, ok);
			chk(q, hpc_rdata, "data read");
			chk({30'h0, ok, hpc_rd}, 32'h3, "read claim");
			host.io(i[0], b + 32'h2 + i, d, q, ok);
			chk({31'h0, ok}, 32'h0, "stray address");
		end
		$display("test io port done");
		rg(1, OFF_POWER_MGMT_CTRL_STATUS, 32'h0000_7EFC);
		rg(0, OFF_POWER_MGMT_CTRL_STATUS, 0);
		chk(q, 32'h0, "read-zero fields");
		for (i = 1; i < 5; i++) begin
			rg(1, OFF_POWER_MGMT_CTRL_STATUS, 32'h0100 | (i % 4));
			rg(0, OFF_POWER_MGMT_CTRL_STATUS, 0);
			chk(q, pm(0, 1, 2'(i % 4)), "power state");
			chk({30'h0, power_state}, i % 4, "state port");
		end
		repeat (2) @(posedge mclk);
		chk(sr_cnt, 1, "internal reset count");
		rg(0, OFF_INDEX_DATA_IO_BASE, 0);
		chk(q, b, "base kept");
		host.cfg(1, OFF_INDEX_DATA_IO_BASE, 4'h2, 32'hFFFF_FFFF, q, ok);
		rg(0, OFF_INDEX_DATA_IO_BASE, 0);
		chk(q, {b[31:16], 8'hFF, b[7:0]}, "base byte lane");
		$display("test power state done");
		pulse(1);
		rg(0, OFF_POWER_MGMT_CTRL_STATUS, 0);
		chk(q, pm(1, 1, 0), "wake enabled");
		chk({31'h0, wake_oe}, 32'h1, "wake pin enabled");
		rg(1, OFF_POWER_MGMT_CTRL_STATUS, 32'h0000_0100);
		rg(0, OFF_POWER_MGMT_CTRL_STATUS, 0);
		chk(q, pm(1, 1, 0), "write zero keeps");
		rg(1, OFF_POWER_MGMT_CTRL_STATUS, 32'h0000_8100);
		rg(0, OFF_POWER_MGMT_CTRL_STATUS, 0);
		chk(q | wake_oe, pm(0, 1, 0), "write one clears");
		rg(1, OFF_POWER_MGMT_CTRL_STATUS, 32'h0);
		pulse(1);
		rg(0, OFF_POWER_MGMT_CTRL_STATUS, 0);
		chk(q | wake_oe, pm(1, 0, 0), "wake suppressed");
		rg(1, OFF_POWER_MGMT_CTRL_STATUS, 32'h0000_0102);
		pulse(0);
		rg(0, OFF_POWER_MGMT_CTRL_STATUS, 0);
		chk(q, pm(1, 1, 0), "bus reset keeps wake bits");
		rg(0, OFF_INDEX_DATA_IO_BASE, 0);
		chk(q, 32'h0, "bus reset clears base");
		host.io(0, b, 0, q, ok);
		chk({31'h0, ok}, 32'h0, "no claim after bus reset");
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		rg(0, OFF_POWER_MGMT_CTRL_STATUS, 0);
		chk(q, 32'h0, "global reset clears");
		$display("test wake done");
		results;
	end
endmodule
`default_nettype wire
